// File: core/srt_lane.sv
// One lane: recovered character clock generator and reference-clock elastic stage
`timescale 1ns/1ps
`include "srt_rx_timing_regs.svh"

module srt_lane (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic bitTick,
   input wire logic refTick,
   input wire srt_pkg::srt_char_t charIn,
   input wire logic fastReq,
   input wire logic slowReq,
   input wire logic idleAddDropEnable,
   output logic recClk,
   output logic recRise,
   output logic recFall,
   output srt_pkg::srt_char_t recChar,
   output srt_pkg::srt_char_t refChar,
   output logic slipEvent
);

   // ----------------------------------------------------------------
   // Recovered clock
   // ----------------------------------------------------------------
   logic [3:0] bitCnt_q;
   logic [3:0] termCnt_q;
   logic [3:0] termCnt_d;
   logic fastPend_q;
   logic slowPend_q;
   logic wrap;
   logic [3:0] bitCntNext;
   srt_pkg::srt_cycle_t cycleKind;

   assign wrap = bitTick && (bitCnt_q == termCnt_q - 4'h1);
   assign bitCntNext = wrap ? 4'h0 : bitCnt_q + 4'h1;

   // A fast and a slow request that meet cancel out
   always_comb
   begin
      if (fastPend_q && !slowPend_q)
         cycleKind = srt_pkg::SRT_CYC_SHORT;
      else if (slowPend_q && !fastPend_q)
         cycleKind = srt_pkg::SRT_CYC_LONG;
      else
         cycleKind = srt_pkg::SRT_CYC_NORMAL;
      unique case (cycleKind)
         srt_pkg::SRT_CYC_SHORT: termCnt_d = `SRT_BITS_SHORT;
         srt_pkg::SRT_CYC_LONG: termCnt_d = `SRT_BITS_LONG;
         srt_pkg::SRT_CYC_NORMAL: termCnt_d = `SRT_BITS_NORMAL;
         default: termCnt_d = `SRT_BITS_NORMAL;
      endcase
   end

   // Each tracker request stands for two bit-times of drift, so one
   // shortened or stretched cycle absorbs it and the spacing follows the offset
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fastPend_q <= 1'b0;
         slowPend_q <= 1'b0;
      end
      else
      begin
         fastPend_q <= fastReq || (fastPend_q && !wrap);
         slowPend_q <= slowReq || (slowPend_q && !wrap);
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bitCnt_q <= 4'h0;
         termCnt_q <= `SRT_BITS_NORMAL;
         recClk <= 1'b0;
      end
      else if (bitTick)
      begin
         bitCnt_q <= bitCntNext;
         if (wrap)
            termCnt_q <= termCnt_d;
         recClk <= wrap ? 1'b1 : (bitCntNext < {1'b0, termCnt_q[3:1]});
      end
   end

   assign recRise = wrap;
   assign recFall = bitTick && !wrap && (bitCntNext == {1'b0, termCnt_q[3:1]});

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         recChar <= `SRT_CHAR_RESET;
      else if (wrap)
         recChar <= charIn;
   end

   // ----------------------------------------------------------------
   // Elastic stage toward the reference clock
   // ----------------------------------------------------------------
   srt_pkg::srt_char_t mem [4];
   logic [1:0] wrPtr_q;
   logic [1:0] rdPtr_q;
   logic [2:0] level_q;
   logic errPend_q;
   logic dropIdle;
   logic overrun;
   logic doWrite;
   logic underrun;
   logic doRead;

   // Idles are dropped early, before the stage is full, to leave headroom
   assign dropIdle = wrap && idleAddDropEnable && charIn.idle && (level_q >= `SRT_FIFO_HIGH);
   assign overrun = wrap && !dropIdle && (level_q == `SRT_FIFO_DEPTH) && !refTick;
   assign doWrite = wrap && !dropIdle && !overrun;
   assign underrun = refTick && (level_q == 3'h0);
   assign doRead = refTick && !underrun;
   assign slipEvent = overrun || (underrun && !idleAddDropEnable);

   always_ff @(posedge clk)
   begin
      if (doWrite)
         mem[wrPtr_q] <= charIn;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wrPtr_q <= 2'h0;
         rdPtr_q <= 2'h0;
         level_q <= 3'h0;
      end
      else
      begin
         if (doWrite)
            wrPtr_q <= wrPtr_q + 2'h1;
         if (doRead)
            rdPtr_q <= rdPtr_q + 2'h1;
         level_q <= level_q + {2'h0, doWrite} - {2'h0, doRead};
      end
   end

   // Overrun seen between reference ticks is held until the next output slot
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         errPend_q <= 1'b0;
      else if (overrun)
         errPend_q <= 1'b1;
      else if (refTick)
         errPend_q <= 1'b0;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         refChar <= `SRT_CHAR_RESET;
      else if (refTick)
      begin
         if (errPend_q || (underrun && !idleAddDropEnable))
            refChar <= '{data: 10'h000, idle: 1'b1, special: 1'b0, err: 1'b1};
         else if (underrun)
            refChar <= '{data: `SRT_IDLE_CODE, idle: 1'b1, special: 1'b1, err: 1'b0};
         else
            refChar <= mem[rdPtr_q];
      end
   end

endmodule

// File: core/srt_rx_timing_regs.svh
// Timing counts and field constants for the receive clock timing block
`ifndef SRT_RX_TIMING_REGS_SVH
`define SRT_RX_TIMING_REGS_SVH

// ----------------------------------------------------------------
// Character period in bit-times
// ----------------------------------------------------------------
`define SRT_BITS_NORMAL 4'hA
`define SRT_BITS_SHORT 4'h8
`define SRT_BITS_LONG 4'hC

// ----------------------------------------------------------------
// Reference character clock
// ----------------------------------------------------------------
`define SRT_REF_LAST 4'h9
`define SRT_REF_MID 4'h5

// ----------------------------------------------------------------
// Elastic stage
// ----------------------------------------------------------------
`define SRT_FIFO_DEPTH 3'h4
`define SRT_FIFO_HIGH 3'h3

// ----------------------------------------------------------------
// Idle character (first disparity form), reset values and lane count
// ----------------------------------------------------------------
`define SRT_IDLE_CODE 10'h17C
`define SRT_CHAR_RESET 13'h0000
`define SRT_LANES 4

`endif

// File: core/srt_pkg.sv
// Types shared by the receive clock timing block
package srt_pkg;

   typedef struct packed {
      logic [9:0] data;
      logic idle;
      logic special;
      logic err;
   } srt_char_t;

   typedef enum logic [1:0] {
      SRT_CYC_NORMAL,
      SRT_CYC_SHORT,
      SRT_CYC_LONG
   } srt_cycle_t;

endpackage

// File: core/srt_rx_timing.sv
// Four-lane receive output timing: recovered or reference clock, elastic stage, word sync
`timescale 1ns/1ps
`include "srt_rx_timing_regs.svh"


module srt_rx_timing (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic recovered_clock_select,
   input wire logic idle_add_drop_enable,
   input wire logic word_sync_enable,
   input wire logic half_speed_enable,
   input wire logic double_rate_enable,
   input wire logic wordSyncAcquired,
   input wire srt_pkg::srt_char_t laneCharIn [`SRT_LANES],
   input wire logic [3:0] laneFastReq,
   input wire logic [3:0] laneSlowReq,
   output logic lane_a_recovered_clock,
   output logic lane_b_recovered_clock,
   output logic lane_c_recovered_clock,
   output logic lane_d_recovered_clock,
   output logic refCharClock,
   output srt_pkg::srt_char_t laneCharOut [`SRT_LANES],
   output logic [4:0] laneDdrHalf [`SRT_LANES],
   output logic wordSyncLocked
);

   // ----------------------------------------------------------------
   // Bit-time and reference character ticks
   // ----------------------------------------------------------------
   logic halfPhase_q;
   logic bitTick;
   logic [3:0] refCnt_q;
   logic refTick;
   logic refMidTick;

   // Half-speed stretches every bit-time to two clocks
   assign bitTick = !half_speed_enable || halfPhase_q;
   assign refTick = bitTick && (refCnt_q == `SRT_REF_LAST);
   assign refMidTick = bitTick && (refCnt_q == `SRT_REF_MID - 4'h1);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         halfPhase_q <= 1'b0;
      else
         halfPhase_q <= half_speed_enable && !halfPhase_q;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         refCnt_q <= 4'h0;
      else if (bitTick)
         refCnt_q <= (refCnt_q == `SRT_REF_LAST) ? 4'h0 : refCnt_q + 4'h1;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         refCharClock <= 1'b0;
      else if (bitTick)
         refCharClock <= (refCnt_q == `SRT_REF_LAST) || (refCnt_q < `SRT_REF_MID - 4'h1);
   end

   // ----------------------------------------------------------------
   // Lanes
   // ----------------------------------------------------------------
   logic [3:0] recClk;
   logic [3:0] recRise;
   logic [3:0] recFall;
   logic [3:0] slip;
   srt_pkg::srt_char_t recChar [`SRT_LANES];
   srt_pkg::srt_char_t refChar [`SRT_LANES];

   for (genvar i = 0; i < `SRT_LANES; i++)
   begin : g_lane
      srt_lane u_lane (
         .clk(clk),
         .reset_n(reset_n),
         .bitTick(bitTick),
         .refTick(refTick),
         .charIn(laneCharIn[i]),
         .fastReq(laneFastReq[i]),
         .slowReq(laneSlowReq[i]),
         .idleAddDropEnable(idle_add_drop_enable),
         .recClk(recClk[i]),
         .recRise(recRise[i]),
         .recFall(recFall[i]),
         .recChar(recChar[i]),
         .refChar(refChar[i]),
         .slipEvent(slip[i])
      );
   end

   assign lane_a_recovered_clock = recClk[0];
   assign lane_b_recovered_clock = recClk[1];
   assign lane_c_recovered_clock = recClk[2];
   assign lane_d_recovered_clock = recClk[3];

   // ----------------------------------------------------------------
   // Word synchronization lock
   // ----------------------------------------------------------------
   logic partialSlip;

   // Deliberately blind to clock select, half-speed and double rate
   assign partialSlip = (slip != 4'h0) && (slip != 4'hF);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         wordSyncLocked <= 1'b0;
      else if (!word_sync_enable || partialSlip)
         wordSyncLocked <= 1'b0;
      else if (wordSyncAcquired)
         wordSyncLocked <= 1'b1;
   end

   // ----------------------------------------------------------------
   // Output timing
   // ----------------------------------------------------------------
   // Lanes B to D follow lane A in word sync with the recovered clock selected; their own clocks no longer match the data
   for (genvar i = 0; i < `SRT_LANES; i++)
   begin : g_out
      logic rise;
      logic fall;
      srt_pkg::srt_char_t src;

      always_comb
      begin
         if (recovered_clock_select)
         begin
            rise = word_sync_enable ? recRise[0] : recRise[i];
            fall = word_sync_enable ? recFall[0] : recFall[i];
            // A lane whose own boundary falls on this rise presents the character just taken
            src = recRise[i] ? laneCharIn[i] : recChar[i];
         end
         else
         begin
            rise = refTick;
            fall = refMidTick;
            src = refChar[i];
         end
      end

      // The slip code arrives already formed in the character: err, idle, not special
      always_ff @(posedge clk or negedge reset_n)
      begin
         if (!reset_n)
            laneCharOut[i] <= `SRT_CHAR_RESET;
         else if (rise)
            laneCharOut[i] <= src;
      end

      // Low half on the rising edge, high half on the falling edge
      always_ff @(posedge clk or negedge reset_n)
      begin
         if (!reset_n)
            laneDdrHalf[i] <= 5'h00;
         else if (rise)
            laneDdrHalf[i] <= src.data[4:0];
         else if (fall && double_rate_enable)
            laneDdrHalf[i] <= laneCharOut[i].data[9:5];
      end
   end

endmodule

// File: bench/srt_rx_timing_monitor.sv
// Port-level checker for the receive clock timing block
`timescale 1ns/1ps
`include "srt_rx_timing_regs.svh"

module srt_rx_timing_monitor (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic recovered_clock_select,
   input wire logic word_sync_enable,
   input wire logic half_speed_enable,
   input wire logic wordSyncAcquired,
   input wire logic lane_a_recovered_clock,
   input wire logic lane_b_recovered_clock,
   input wire logic refCharClock,
   input wire srt_pkg::srt_char_t laneCharOut [`SRT_LANES],
   input wire logic wordSyncLocked
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   rec_min_period_a: assert property ($rose(lane_a_recovered_clock) |=> (!$rose(lane_a_recovered_clock))[*7])
      else $error("recovered clock period below eight bit-times");
   rec_max_period_a: assert property ($rose(lane_a_recovered_clock) |-> ##[8:24] $rose(lane_a_recovered_clock))
      else $error("recovered clock period too long");
   rec_high_time_a: assert property ($rose(lane_a_recovered_clock) |-> lane_a_recovered_clock[*4])
      else $error("recovered clock high phase too short");
   ref_clock_shape_a: assert property (disable iff (!reset_n || half_speed_enable)
      $fell(refCharClock) |-> (!refCharClock)[*5] ##1 refCharClock[*5] ##1 !refCharClock)
      else $error("reference character clock shape wrong");
   ref_mode_timing_a: assert property (!recovered_clock_select && $past(!recovered_clock_select)
      && $changed(laneCharOut[0]) |-> $rose(refCharClock))
      else $error("reference mode output changed off the clock rise");
   rec_lane_timing_a: assert property (!word_sync_enable && $past(!word_sync_enable) && recovered_clock_select
      && $past(recovered_clock_select) && $changed(laneCharOut[1]) |-> $rose(lane_b_recovered_clock))
      else $error("lane B output changed off its clock rise");
   sync_lane_timing_a: assert property (word_sync_enable && $past(word_sync_enable) && recovered_clock_select
      && $past(recovered_clock_select) && $changed(laneCharOut[2]) |-> $rose(lane_a_recovered_clock))
      else $error("word sync output changed off lane A clock rise");
   slip_code_a: assert property (laneCharOut[0].err |-> laneCharOut[0].idle && !laneCharOut[0].special)
      else $error("slip error code malformed");
   slip_hold_a: assert property ($rose(laneCharOut[0].err) |-> laneCharOut[0].err[*8])
      else $error("slip error shorter than a character period");
   lock_set_a: assert property (word_sync_enable && wordSyncAcquired |=> wordSyncLocked)
      else $error("word sync lock not taken");
   lock_clear_a: assert property (!word_sync_enable |=> !wordSyncLocked)
      else $error("word sync lock held while disabled");
endmodule

// File: bench/srt_char_source.sv
// Far-side stream model: counting characters with an idle every few characters
`timescale 1ns/1ps
`include "srt_rx_timing_regs.svh"

module srt_char_source #(
   parameter int IDLE_GAP = 3
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] recClk,
   input wire logic noIdle,
   output srt_pkg::srt_char_t laneCharIn [`SRT_LANES]
);
   logic [3:0] prevClk;
   int count [`SRT_LANES];
   // Idles use the other disparity form so an inserted idle stays distinguishable
   always @(negedge clk or negedge reset_n)
   begin
      for (int i = 0; i < `SRT_LANES; i++)
      begin
         if (!reset_n)
         begin
            count[i] = 0;
            laneCharIn[i] = '0;
         end
         else if (recClk[i] && !prevClk[i])
         begin
            count[i] = count[i] + 1;
            if (!noIdle && count[i] % (IDLE_GAP + 1) == 0)
               laneCharIn[i] = '{10'h283, 1'h1, 1'h1, 1'h0};
            else
               laneCharIn[i] = '{10'(count[i] * 7 + i), 1'h0, 1'h0, 1'h0};
         end
      end
      prevClk = reset_n ? recClk : 4'h0;
   end
endmodule

// File: bench/test_srt_rx_timing.sv
// Self-checking bench for the receive clock timing block
`timescale 1ns/1ps
`include "srt_rx_timing_regs.svh"

module test_srt_rx_timing;
   logic clk, reset_n, recSel, addDropEn, syncEn, halfSpeed, doubleRate, syncAcquired, noIdle;
   logic [3:0] fastReq, slowReq;
   logic laneA, laneB, laneC, laneD, refClk, locked;
   srt_pkg::srt_char_t laneCharIn [`SRT_LANES];
   srt_pkg::srt_char_t laneCharOut [`SRT_LANES];
   logic [4:0] ddrHalf [`SRT_LANES];
   int num_errors = 0;
   int comparisons = 0;

   srt_rx_timing u_srt_rx_timing (.clk(clk), .reset_n(reset_n), .recovered_clock_select(recSel),
      .idle_add_drop_enable(addDropEn), .word_sync_enable(syncEn), .half_speed_enable(halfSpeed),
      .double_rate_enable(doubleRate), .wordSyncAcquired(syncAcquired), .laneCharIn(laneCharIn),
      .laneFastReq(fastReq), .laneSlowReq(slowReq), .lane_a_recovered_clock(laneA),
      .lane_b_recovered_clock(laneB), .lane_c_recovered_clock(laneC), .lane_d_recovered_clock(laneD),
      .refCharClock(refClk), .laneCharOut(laneCharOut), .laneDdrHalf(ddrHalf), .wordSyncLocked(locked));
   srt_char_source u_srt_char_source (.clk(clk), .reset_n(reset_n), .recClk({laneD, laneC, laneB, laneA}),
      .noIdle(noIdle), .laneCharIn(laneCharIn));

   always #5 clk = ~clk;

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic do_reset();
      reset_n = 1'h0;
      repeat (12) @(negedge clk);
      reset_n = 1'h1;
   endtask

   // Returns cycles to the next lane A rise; a rise already in progress does not count
   task automatic wait_rise(output int n);
      logic prev;
      prev = 1'h1;
      n = 0;
      while (!(laneA && !prev) && n < 40)
      begin
         prev = laneA;
         @(negedge clk);
         n++;
      end
      if (n >= 40)
      begin
         num_errors++;
         $display("MISMATCH lane A rise expected within 40 seen none");
         wrap_up();
      end
   endtask

   // Request lands right after a rise, so it shapes the period after the next one
   task automatic test_period(input logic [3:0] f, input logic [3:0] s, input logic [15:0] exp);
      int n;
      wait_rise(n);
      fastReq = f;
      slowReq = s;
      @(negedge clk);
      fastReq = 4'h0;
      slowReq = 4'h0;
      wait_rise(n);
      wait_rise(n);
      check("lane A period", exp, 16'(n));
   endtask

   // Lane B: whole character at the rise, upper half five bit-times later
   task automatic test_rec_data();
      logic prev;
      int c;
      srt_pkg::srt_char_t want;
      prev = 1'h1;
      c = 0;
      while (!(laneB && !prev) && c < 30)
      begin
         prev = laneB;
         @(posedge clk);
         #1;
         c++;
      end
      if (c >= 30)
      begin
         num_errors++;
         $display("MISMATCH lane B rise expected within 30 seen none");
         wrap_up();
      end
      want = laneCharIn[1];
      check("lane B char", 16'(want), 16'(laneCharOut[1]));
      check("lane B low half", 16'(want.data[4:0]), 16'(ddrHalf[1]));
      repeat (5) @(posedge clk);
      #1;
      check("lane B high half", 16'(want.data[9:5]), 16'(ddrHalf[1]));
      @(negedge clk);
   endtask

   // Lane 0 runs every period short or long against the reference reads
   task automatic test_drift(input logic fast, input logic en, input logic starve, input logic expErr,
      input logic needIns);
      logic prev, sawErr, sawIns;
      prev = 1'h1;
      sawErr = 1'h0;
      sawIns = 1'h0;
      recSel = 1'h0;
      addDropEn = en;
      noIdle = starve;
      for (int c = 0; c < 1000; c++)
      begin
         @(negedge clk);
         fastReq = (fast && laneA && !prev) ? 4'h1 : 4'h0;
         slowReq = (!fast && laneA && !prev) ? 4'h1 : 4'h0;
         prev = laneA;
         // The start-up underrun is skipped so that only the steady drift can satisfy it
         if (laneCharOut[0].err === 1'h1 && (c >= 200 || !expErr))
            sawErr = 1'h1;
         if (c >= 200 && laneCharOut[0].data === `SRT_IDLE_CODE && laneCharOut[0].idle === 1'h1)
            sawIns = 1'h1;
      end
      fastReq = 4'h0;
      slowReq = 4'h0;
      check("slip error seen", 16'(expErr), 16'(sawErr));
      if (needIns)
         check("idle inserted", 16'h1, 16'(sawIns));
   endtask

   task automatic test_word_sync();
      do_reset();
      recSel = 1'h0;
      doubleRate = 1'h1;
      syncEn = 1'h1;
      syncAcquired = 1'h1;
      @(negedge clk);
      syncAcquired = 1'h0;
      check("lock set", 16'h1, 16'(locked));
      test_drift(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
      check("lock with add/drop", 16'h1, 16'(locked));
      test_drift(1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
      check("lock after one-lane slip", 16'h0, 16'(locked));
      recSel = 1'h1;
      test_period(4'h1, 4'h0, 16'h8);
      syncEn = 1'h0;
   endtask

   initial
   begin
      clk = 1'h0;
      {recSel, addDropEn, syncEn, halfSpeed, doubleRate, syncAcquired, noIdle} = 7'h40;
      fastReq = 4'h0;
      slowReq = 4'h0;
      do_reset();
      test_period(4'h0, 4'h0, 16'hA);
      test_period(4'h1, 4'h0, 16'h8);
      test_period(4'h0, 4'h1, 16'hC);
      test_period(4'h1, 4'h1, 16'hA);
      halfSpeed = 1'h1;
      test_period(4'h0, 4'h0, 16'h14);
      halfSpeed = 1'h0;
      doubleRate = 1'h1;
      test_rec_data();
      do_reset();
      test_drift(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
      do_reset();
      test_drift(1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
      do_reset();
      test_drift(1'h1, 1'h1, 1'h1, 1'h1, 1'h0);
      do_reset();
      test_drift(1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
      do_reset();
      test_drift(1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
      test_word_sync();
      wrap_up();
   end
endmodule

bind srt_rx_timing srt_rx_timing_monitor u_srt_rx_timing_monitor (.clk, .reset_n, .recovered_clock_select,
   .word_sync_enable, .half_speed_enable, .wordSyncAcquired, .lane_a_recovered_clock, .lane_b_recovered_clock,
   .refCharClock, .laneCharOut, .wordSyncLocked);
